// File: hdl/encoder_pulse_counter_decode.sv
`timescale 1ns/10ps
`default_nettype none

module encoder_pulse_counter_decode #(
  parameter encoder_counter_pkg::filter_table_type FILTER_CYCLES =
    encoder_counter_pkg::FILTER_CYCLES_DEFAULT
) (
  // Clock and reset.
  input  wire logic                                   ref_clk_in,
  input  wire logic                                   reset_in,
  // Encoder pins.
  input  wire encoder_counter_pkg::encoder_type       encoder_in,
  // Avalon-MM slave.
  input  wire logic [encoder_counter_pkg::ADDR_WIDTH-1:0] address_in,
  input  wire logic                                   read_in,
  input  wire logic                                   write_in,
  input  wire logic [encoder_counter_pkg::DATA_WIDTH-1:0] writedata_in,
  input  wire logic [encoder_counter_pkg::BE_WIDTH-1:0]   byteenable_in,
  output logic [encoder_counter_pkg::DATA_WIDTH-1:0]  readdata_out,
  output logic                                        waitrequest_out
);
  import encoder_counter_pkg::*;

  ctrl_type                ctrl_reg;
  logic [COUNT_WIDTH-1:0]  upper_count_limit_reg [2];
  logic [COUNT_WIDTH-1:0]  lower_count_limit_reg [2];
  logic [COUNT_WIDTH-1:0]  present_count_value_reg [2];
  logic [COUNT_WIDTH-1:0]  captured_count_value_reg;
  logic [FLAG_WIDTH-1:0]   flag_reg;
  logic [DATA_WIDTH-1:0]   readdata_reg;
  logic                    waitrequest_reg;
  logic [DATA_WIDTH-1:0]   readdata_next;
  logic [INPUT_COUNT-1:0]  filtered;
  logic [INPUT_COUNT-1:0]  prev_reg;
  logic [FILTER_CNT_WIDTH-1:0] threshold;
  logic                    filter_on;
  logic                    write_accept;
  logic [FLAG_WIDTH-1:0]   flag_clear;
  logic [FLAG_WIDTH-1:0]   flag_set;
  logic [1:0]              cnt_up;
  logic [1:0]              cnt_dn;
  logic                    a_now;
  logic                    b_now;
  logic                    a_was;
  logic                    b_was;
  logic                    a_rise;
  logic                    b_rise;
  logic                    b1_rise;
  logic                    z_rise;
  logic                    reset_hold;
  logic                    clear_at_upper;
  logic [COUNT_WIDTH+1:0]  step_result [2];

  // Filter settings zero and 15 bypass; settings 1 to 14 pick a threshold from the table.
  assign filter_on = (ctrl_reg.filter_select != 4'h0) &&
                     (ctrl_reg.filter_select <= 4'(FILTER_SETTINGS));
  assign threshold = filter_on ? FILTER_CYCLES[ctrl_reg.filter_select]
                               : FILTER_CYCLES[1];

  // One synchroniser and filter per encoder input.
  generate
    for (genvar i = 0; i < INPUT_COUNT; i++) begin : g_filter
      input_pulse_filter u_filter (
        .ref_clk_in   (ref_clk_in),
        .reset_in     (reset_in),
        .raw_in       (encoder_in[i]),
        .enable_in    (filter_on),
        .threshold_in (threshold),
        .filtered_out (filtered[i])
      );
    end
  endgenerate

  // Previous filtered levels for edge detection.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= filtered;
    end
  end

  // With two counters B belongs to counter one, so counter zero sees it low.
  assign a_now  = filtered[A_BIT];
  assign a_was  = prev_reg[A_BIT];
  assign b_now  = ctrl_reg.two_counters ? 1'b0 : filtered[B_BIT];
  assign b_was  = ctrl_reg.two_counters ? 1'b0 : prev_reg[B_BIT];
  assign a_rise = a_now && !a_was;
  assign b_rise = b_now && !b_was;
  assign b1_rise = ctrl_reg.two_counters &&
                   filtered[B_BIT] && !prev_reg[B_BIT];
  assign z_rise = filtered[Z_BIT] && !prev_reg[Z_BIT];
  assign reset_hold = ctrl_reg.counter_count_select[0] &&
                      (ctrl_reg.counter_count_select != MODE_IDLE_B);
  assign clear_at_upper = (ctrl_reg.counter_count_select == MODE_UP) ||
                          (ctrl_reg.counter_count_select == MODE_UP_RH);

  // One step per edge per cycle at core rate, so no filtered pulse is lost.
  always_comb begin
    cnt_up = 2'b00;
    cnt_dn = 2'b00;
    case (ctrl_reg.counter_count_select)
      MODE_UP, MODE_UP_RH: begin
        cnt_up[0] = a_rise;
        cnt_up[1] = b1_rise;
      end
      MODE_DIR, MODE_DIR_RH: begin
        cnt_up[0] = a_rise && !b_now;
        cnt_dn[0] = a_rise && b_now;
        cnt_up[1] = b1_rise;
      end
      MODE_UPDN, MODE_UPDN_RH: begin
        cnt_up[0] = a_rise && !b_rise;
        cnt_dn[0] = b_rise && !a_rise;
        cnt_up[1] = b1_rise;
      end
      MODE_QUAD1, MODE_QUAD1_RH: begin
        cnt_up[0] = a_rise && !b_now;
        cnt_dn[0] = a_rise && b_now;
        cnt_up[1] = b1_rise;
      end
      MODE_QUAD4, MODE_QUAD4_RH: begin
        // Only single-input changes are legal quadrature steps.
        cnt_up[0] = ((a_now ^ a_was) ^ (b_now ^ b_was)) &&
                    (a_now ^ b_was);
        cnt_dn[0] = ((a_now ^ a_was) ^ (b_now ^ b_was)) &&
                    !(a_now ^ b_was);
        cnt_up[1] = b1_rise;
      end
      MODE_QUAD2, MODE_QUAD2_RH: begin
        cnt_up[0] = (a_now ^ a_was) && (a_now ^ b_now);
        cnt_dn[0] = (a_now ^ a_was) && !(a_now ^ b_now);
        cnt_up[1] = b1_rise;
      end
      MODE_DOWN, MODE_DOWN_RH: begin
        cnt_dn[0] = a_rise;
        cnt_dn[1] = b1_rise;
      end
      default: begin
        cnt_up = 2'b00;
        cnt_dn = 2'b00;
      end
    endcase
  end

  // Next count with limit handling; returns {overflow, underflow, count}.
  function automatic logic [COUNT_WIDTH+1:0] step_count(
    input logic [COUNT_WIDTH-1:0] count,
    input logic                   up,
    input logic                   dn,
    input logic [COUNT_WIDTH-1:0] upper,
    input logic [COUNT_WIDTH-1:0] lower,
    input logic                   saturate,
    input logic                   clear_mode
  );
    logic [COUNT_WIDTH-1:0] nxt;
    logic                   ovf;
    logic                   unf;
    nxt = count;
    ovf = 1'b0;
    unf = 1'b0;
    if (up && clear_mode) begin
      nxt = count + 32'h00000001;
      if ($signed(nxt) >= $signed(upper)) begin
        nxt = COUNT_RESET;
        ovf = 1'b1;
      end
    end else if (up) begin
      if (count == upper) begin
        nxt = saturate ? upper : lower;
        ovf = 1'b1;
      end else begin
        nxt = count + 32'h00000001;
      end
    end else if (dn) begin
      if (count == lower) begin
        nxt = saturate ? lower : upper;
        unf = 1'b1;
      end else begin
        nxt = count - 32'h00000001;
      end
    end
    return {ovf, unf, nxt};
  endfunction

  // Both counters share the same limit logic.
  generate
    for (genvar n = 0; n < 2; n++) begin : g_step
      assign step_result[n] = step_count(present_count_value_reg[n],
        cnt_up[n], cnt_dn[n], upper_count_limit_reg[n],
        lower_count_limit_reg[n], ctrl_reg.wrap_or_saturate_select[n],
        clear_at_upper);
    end
  endgenerate

  // Counter zero; the index input resets or holds it in odd modes other than MODE_IDLE_B.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      present_count_value_reg[0] <= COUNT_RESET;
    end else if (reset_hold && z_rise) begin
      present_count_value_reg[0] <= COUNT_RESET;
    end else if (reset_hold && filtered[Z_BIT]) begin
      present_count_value_reg[0] <= present_count_value_reg[0];
    end else begin
      present_count_value_reg[0] <= step_result[0][COUNT_WIDTH-1:0];
    end
  end

  // Counter one never sees the index, which belongs to counter zero.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      present_count_value_reg[1] <= COUNT_RESET;
    end else begin
      present_count_value_reg[1] <= step_result[1][COUNT_WIDTH-1:0];
    end
  end

  // Capture on the index edge in reset-hold modes; a later edge simply overwrites it.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      captured_count_value_reg <= COUNT_RESET;
    end else if (reset_hold && z_rise) begin
      captured_count_value_reg <= present_count_value_reg[0];
    end
  end

  // Flags only count when the counter wrapped, saturated or cleared at the upper limit, not while held.
  assign flag_set[OVF0_BIT] = step_result[0][COUNT_WIDTH+1] &&
                              !(reset_hold && filtered[Z_BIT]);
  assign flag_set[UNF0_BIT] = step_result[0][COUNT_WIDTH] &&
                              !(reset_hold && filtered[Z_BIT]);
  assign flag_set[OVF1_BIT] = step_result[1][COUNT_WIDTH+1];
  assign flag_set[UNF1_BIT] = step_result[1][COUNT_WIDTH];

  // Register access completes on the second edge of a request.
  assign write_accept = write_in && !waitrequest_reg;
  assign flag_clear   = (write_accept && (address_in == STATUS_OFFSET) &&
                         byteenable_in[0]) ? writedata_in[FLAG_WIDTH-1:0]
                                           : 4'h0;

  // Sticky flags; a new event beats a clear in the same cycle.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      flag_reg <= 4'h0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clear) | flag_set;
    end
  end

  // Byte-enable merge for register writes.
  function automatic logic [DATA_WIDTH-1:0] merge(
    input logic [DATA_WIDTH-1:0] old,
    input logic [DATA_WIDTH-1:0] wdata,
    input logic [BE_WIDTH-1:0]   be
  );
    logic [DATA_WIDTH-1:0] res;
    res = old;
    for (int i = 0; i < BE_WIDTH; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Control register; mode changes take effect on the next edge.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (write_accept && (address_in == CTRL_OFFSET)) begin
      ctrl_reg <= ctrl_type'(merge(DATA_WIDTH'(ctrl_reg), writedata_in,
                                   byteenable_in));
    end
  end

  // Limit registers, one pair per counter.
  generate
    for (genvar n = 0; n < 2; n++) begin : g_limits
      always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
          upper_count_limit_reg[n] <= UPPER_RESET;
          lower_count_limit_reg[n] <= LOWER_RESET;
        end else if (write_accept) begin
          if (address_in == (n == 0 ? UPPER0_OFFSET : UPPER1_OFFSET)) begin
            upper_count_limit_reg[n] <= merge(upper_count_limit_reg[n],
                                              writedata_in, byteenable_in);
          end else if (address_in ==
                       (n == 0 ? LOWER0_OFFSET : LOWER1_OFFSET)) begin
            lower_count_limit_reg[n] <= merge(lower_count_limit_reg[n],
                                              writedata_in, byteenable_in);
          end
        end
      end
    end
  endgenerate

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    if (address_in == CTRL_OFFSET) begin
      readdata_next = DATA_WIDTH'(ctrl_reg);
    end else if (address_in == STATUS_OFFSET) begin
      readdata_next = DATA_WIDTH'(flag_reg);
    end else if (address_in == UPPER0_OFFSET) begin
      readdata_next = upper_count_limit_reg[0];
    end else if (address_in == LOWER0_OFFSET) begin
      readdata_next = lower_count_limit_reg[0];
    end else if (address_in == UPPER1_OFFSET) begin
      readdata_next = upper_count_limit_reg[1];
    end else if (address_in == LOWER1_OFFSET) begin
      readdata_next = lower_count_limit_reg[1];
    end else if (address_in == COUNT0_OFFSET) begin
      readdata_next = present_count_value_reg[0];
    end else if (address_in == COUNT1_OFFSET) begin
      readdata_next = present_count_value_reg[1];
    end else if (address_in == CAPTURE0_OFFSET) begin
      readdata_next = captured_count_value_reg;
    end else begin
      readdata_next = UNMAPPED_READ;
    end
  end

  // Waitrequest drops for one cycle once a request's read data is registered.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= !((read_in || write_in) && waitrequest_reg);
    end
  end

  // Read data is loaded on the edge that first sees the request.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      readdata_reg <= UNMAPPED_READ;
    end else if (read_in && waitrequest_reg) begin
      readdata_reg <= readdata_next;
    end
  end

  assign readdata_out    = readdata_reg;
  assign waitrequest_out = waitrequest_reg;

endmodule // encoder_pulse_counter_decode

`default_nettype wire

// File: hdl/encoder_counter_pkg.sv
package encoder_counter_pkg;

  // Widths of the datapath and of the register bus.
  localparam int COUNT_WIDTH      = 32;
  localparam int ADDR_WIDTH       = 6;
  localparam int DATA_WIDTH       = 32;
  localparam int BE_WIDTH         = 4;
  localparam int INPUT_COUNT      = 3;
  localparam int FILTER_SETTINGS  = 14;
  localparam int FILTER_CNT_WIDTH = 22;
  localparam int FILTER_SEL_WIDTH = 4;

  // Core clock rate used to turn filter times into cycles.
  localparam longint CLOCK_MHZ = 250;

  // Register byte offsets.
  localparam logic [ADDR_WIDTH-1:0] CTRL_OFFSET     = 6'h00;
  localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET   = 6'h04;
  localparam logic [ADDR_WIDTH-1:0] UPPER0_OFFSET   = 6'h08;
  localparam logic [ADDR_WIDTH-1:0] LOWER0_OFFSET   = 6'h0C;
  localparam logic [ADDR_WIDTH-1:0] UPPER1_OFFSET   = 6'h10;
  localparam logic [ADDR_WIDTH-1:0] LOWER1_OFFSET   = 6'h14;
  localparam logic [ADDR_WIDTH-1:0] COUNT0_OFFSET   = 6'h18;
  localparam logic [ADDR_WIDTH-1:0] COUNT1_OFFSET   = 6'h1C;
  localparam logic [ADDR_WIDTH-1:0] CAPTURE0_OFFSET = 6'h20;

  // Status bit positions; software writes a one to clear.
  localparam int OVF0_BIT    = 0;
  localparam int UNF0_BIT    = 1;
  localparam int OVF1_BIT    = 2;
  localparam int UNF1_BIT    = 3;
  localparam int FLAG_WIDTH  = 4;

  // Input bit positions inside the encoder carrier.
  localparam int A_BIT = 0;
  localparam int B_BIT = 1;
  localparam int Z_BIT = 2;

  // Reset values.
  localparam logic [COUNT_WIDTH-1:0] UPPER_RESET = 32'h7FFFFFFF;
  localparam logic [COUNT_WIDTH-1:0] LOWER_RESET = 32'h80000000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h00000000;
  localparam logic [DATA_WIDTH-1:0]  UNMAPPED_READ = 32'h00000000;

  // Counting modes.
  typedef enum logic [3:0] {
    MODE_UP        = 4'b0000,
    MODE_UP_RH     = 4'b0001,
    MODE_DIR       = 4'b0010,
    MODE_DIR_RH    = 4'b0011,
    MODE_UPDN      = 4'b0100,
    MODE_UPDN_RH   = 4'b0101,
    MODE_QUAD1     = 4'b0110,
    MODE_QUAD1_RH  = 4'b0111,
    MODE_QUAD4     = 4'b1000,
    MODE_QUAD4_RH  = 4'b1001,
    MODE_QUAD2     = 4'b1010,
    MODE_QUAD2_RH  = 4'b1011,
    MODE_DOWN      = 4'b1100,
    MODE_DOWN_RH   = 4'b1101,
    MODE_IDLE_A    = 4'b1110,
    MODE_IDLE_B    = 4'b1111
  } count_select_type;

  // Control register layout, bit 0 upward: mode, counters, filter, limits.
  typedef struct packed {
    logic [1:0]                  wrap_or_saturate_select;
    logic [FILTER_SEL_WIDTH-1:0] filter_select;
    logic                        two_counters;
    count_select_type            counter_count_select;
  } ctrl_type;

  localparam int CTRL_WIDTH = $bits(ctrl_type);
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h000;

  // Encoder inputs as they arrive on the pins.
  typedef struct packed {
    logic index_gate_input;
    logic b;
    logic a;
  } encoder_type;

  // Longest pulse each filter setting must block, in ns, fastest first.
  localparam longint FILTER_BLOCK_NS [1:FILTER_SETTINGS] = '{
    950, 1500, 3900, 8000, 24100, 32100, 80300, 161000,
    330000, 650000, 1300000, 2600000, 5200000, 10300000};

  typedef logic [FILTER_SETTINGS:1][FILTER_CNT_WIDTH-1:0] filter_table_type;

  // A pulse passes once it has stood for the block time, rounded up.
  function automatic filter_table_type make_filter_table();
    filter_table_type t;
    longint           c;
    for (int i = 1; i <= FILTER_SETTINGS; i++) begin
      c = (FILTER_BLOCK_NS[i] * CLOCK_MHZ + 999) / 1000;
      t[i] = c[FILTER_CNT_WIDTH-1:0];
    end
    return t;
  endfunction

  localparam filter_table_type FILTER_CYCLES_DEFAULT = make_filter_table();

endpackage

// File: hdl/input_pulse_filter.sv
`timescale 1ns/10ps
`default_nettype none

module input_pulse_filter (
  // Clock and reset.
  input  wire logic                                       ref_clk_in,
  input  wire logic                                       reset_in,
  // Raw pin and filter setting.
  input  wire logic                                       raw_in,
  input  wire logic                                       enable_in,
  input  wire logic [encoder_counter_pkg::FILTER_CNT_WIDTH-1:0] threshold_in,
  // Filtered level.
  output logic                                            filtered_out
);
  import encoder_counter_pkg::*;

  logic                        sync_first_reg;
  logic                        sync_second_reg;
  logic                        level_reg;
  logic [FILTER_CNT_WIDTH-1:0] stable_reg;

  // Two flops bring the pin into the clock domain.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync_first_reg  <= 1'b0;
      sync_second_reg <= 1'b0;
    end else begin
      sync_first_reg  <= raw_in;
      sync_second_reg <= sync_first_reg;
    end
  end

  // Counts how long the input has differed from the accepted level.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || (sync_second_reg == level_reg)) begin
      stable_reg <= '0;
    end else begin
      stable_reg <= stable_reg + 22'h000001;
    end
  end

  // With the filter enabled, a change is accepted only after it has stood for the threshold; disabled, it passes at once.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      level_reg <= 1'b0;
    end else if (!enable_in) begin
      level_reg <= sync_second_reg;
    end else if ((sync_second_reg != level_reg) &&
                 (stable_reg >= threshold_in - 22'h000001)) begin
      level_reg <= sync_second_reg;
    end
  end

  assign filtered_out = level_reg;

endmodule // input_pulse_filter

`default_nettype wire

// File: sim/encoder_counter_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module encoder_counter_monitor
  import encoder_counter_pkg::*;
(
  // Clock, reset and pins.
  input wire logic                  ref_clk_in,
  input wire logic                  reset_in,
  input wire encoder_type           encoder_in,
  // Register bus.
  input wire logic [ADDR_WIDTH-1:0] address_in,
  input wire logic                  read_in,
  input wire logic                  write_in,
  input wire logic [DATA_WIDTH-1:0] writedata_in,
  input wire logic [BE_WIDTH-1:0]   byteenable_in,
  input wire logic [DATA_WIDTH-1:0] readdata_out,
  input wire logic                  waitrequest_out
);
  // One clock domain, so clock and reset are given once; a_reset_quiet overrides the reset.
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire logic done = read_in && !waitrequest_out;
  a_answer_one_wait: assert property ((read_in || write_in) &&
    waitrequest_out |=> !waitrequest_out) else $error("late answer");
  a_ack_one_cycle: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("ack held too long");
  a_ack_has_cause: assert property ($fell(waitrequest_out) |->
    $past(read_in || write_in)) else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) reset_in |=>
    waitrequest_out && readdata_out == '0) else $error("busy in reset");
  a_unmapped_zero: assert property (done && address_in > CAPTURE0_OFFSET
    |-> readdata_out == '0) else $error("unmapped read not zero");
  a_status_spare_zero: assert property (done && address_in == STATUS_OFFSET
    |-> readdata_out[DATA_WIDTH-1:FLAG_WIDTH] == '0) else $error("status");
  a_ctrl_spare_zero: assert property (done && address_in == CTRL_OFFSET
    |-> readdata_out[DATA_WIDTH-1:CTRL_WIDTH] == '0) else $error("ctrl");
  a_data_stands: assert property (done |=> $stable(readdata_out))
    else $error("read data moved");
endmodule // encoder_counter_monitor
`default_nettype wire

// File: sim/encoder_source_model.sv
`timescale 1ns/10ps
`default_nettype none
module encoder_source_model (
  // Clock and stepping requests.
  input  wire logic ref_clk_in,
  input  wire logic quad_in,
  input  wire logic fwd_in,
  input  wire logic bwd_in,
  input  wire logic a_in,
  input  wire logic b_in,
  input  wire logic z_in,
  // Encoder pins.
  output var encoder_counter_pkg::encoder_type encoder_out
);
  logic [1:0] phase_reg = 2'h0;
  // One quarter cycle per request; backward adds three, i.e. minus one.
  always_ff @(posedge ref_clk_in) begin
    phase_reg <= phase_reg + {bwd_in, fwd_in | bwd_in};
  end
  // Gray phase keeps A a quarter cycle ahead of B going forward.
  assign encoder_out = quad_in ? {z_in, phase_reg[1], ^phase_reg}
                               : {z_in, b_in, a_in};
endmodule // encoder_source_model
`default_nettype wire

// File: sim/encoder_pulse_counter_decode_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module encoder_pulse_counter_decode_tb_top;
  import encoder_counter_pkg::*;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, read = 1'b0, write = 1'b0;
  logic quad = 1'b0, fwd = 1'b0, bwd = 1'b0, a = 1'b0, b = 1'b0, z = 1'b0;
  logic [ADDR_WIDTH-1:0] address = '0;
  logic [DATA_WIDTH-1:0] wdata = '0, rdata, seen;
  logic waitreq;
  logic [31:0] rnd = 32'h10;
  encoder_type enc;
  int errors = 0, comparisons = 0, cycles = 0, exp0 = 0, exp1 = 0;
  int n, m, k, dir, bl;
  encoder_source_model i_src (.ref_clk_in, .quad_in(quad), .fwd_in(fwd),
    .bwd_in(bwd), .a_in(a), .b_in(b), .z_in(z), .encoder_out(enc));
  // Short filter counts keep the filtered cases quick.
  encoder_pulse_counter_decode #(.FILTER_CYCLES({FILTER_SETTINGS{22'h8}}))
    i_dut (.ref_clk_in, .reset_in, .encoder_in(enc), .address_in(address),
    .read_in(read), .write_in(write), .writedata_in(wdata),
    .byteenable_in(4'hF), .readdata_out(rdata), .waitrequest_out(waitreq));
  always #2 ref_clk_in = !ref_clk_in;
  // A hung handshake must still reach the verdict.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  function automatic logic [31:0] xorshift();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask
  // Request held until waitrequest is seen low; one idle edge follows.
  task automatic bus(input logic wr, input logic [5:0] ad, input int d);
    address <= ad;
    wdata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge ref_clk_in); while (waitreq !== 1'b0);
    seen = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [5:0] ad, input int e, input string w);
    bus(1'b0, ad, 0);
    check(w, e, seen);
  endtask
  task automatic pulse(input logic pa, pb, input int w);
    a <= pa;
    if (pb) b <= 1'b1;
    repeat (w) @(posedge ref_clk_in);
    a <= 1'b0;
    if (pb) b <= 1'b0;
    repeat (w + 4) @(posedge ref_clk_in);
  endtask
  task automatic step(input int d);
    fwd <= d[0];
    bwd <= !d[0];
    @(posedge ref_clk_in);
    fwd <= 1'b0;
    bwd <= 1'b0;
    repeat (5) @(posedge ref_clk_in);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(CTRL_OFFSET, CTRL_RESET, "ctrl");
    rd(UPPER0_OFFSET, UPPER_RESET, "upper0");
    bus(1'b1, 6'h24, -1);
    rd(6'h24, 0, "unmapped");
    // Every counting mode with random lengths; MODE_DIR and the quadrature modes also get random directions.
    for (m = 0; m < 14; m++) begin
      n = int'(xorshift() % 4) + 1;
      bl = (m == 2 || m == 3) ? int'(xorshift() & 1) : 0;
      b <= bl[0];
      bus(1'b1, CTRL_OFFSET, m);
      if (m >= 6 && m < 12) begin
        quad <= 1'b1;
        k = m < 8 ? 1 : (m < 10 ? 4 : 2);
        dir = int'(xorshift() & 1);
        repeat (n * 4) step(dir);
        exp0 += dir ? n * k : -n * k;
      end else begin
        quad <= 1'b0;
        repeat (n) pulse(1'b1, 1'b0, 4);
        exp0 += (m > 11 || (m > 1 && bl == 1)) ? -n : n;
      end
      rd(COUNT0_OFFSET, exp0, "count0");
      $display("mode %0d done", m);
    end
    bus(1'b1, CTRL_OFFSET, 4);
    pulse(1'b1, 1'b1, 4);
    rd(COUNT0_OFFSET, exp0, "coincident");
    bus(1'b1, CTRL_OFFSET, 32'h10);
    pulse(1'b0, 1'b1, 4);
    rd(COUNT1_OFFSET, 1, "count1");
    bus(1'b1, CTRL_OFFSET, 1);
    z <= 1'b1;
    pulse(1'b1, 1'b0, 4);
    rd(CAPTURE0_OFFSET, exp0, "capture");
    rd(COUNT0_OFFSET, 0, "held");
    z <= 1'b0;
    $display("index done");
    bus(1'b1, CTRL_OFFSET, 4);
    bus(1'b1, UPPER0_OFFSET, 1);
    repeat (2) pulse(1'b1, 1'b0, 4);
    rd(COUNT0_OFFSET, LOWER_RESET, "wrap");
    rd(STATUS_OFFSET, 1, "ovf");
    bus(1'b1, STATUS_OFFSET, 1);
    rd(STATUS_OFFSET, 0, "clear");
    bus(1'b1, CTRL_OFFSET, 32'h20C);
    pulse(1'b1, 1'b0, 4);
    rd(COUNT0_OFFSET, LOWER_RESET, "saturate");
    rd(STATUS_OFFSET, 2, "unf");
    bus(1'b1, CTRL_OFFSET, 32'h24);
    pulse(1'b1, 1'b0, 3);
    pulse(1'b1, 1'b0, 12);
    rd(COUNT0_OFFSET, 32'h80000001, "filter");
    bus(1'b1, CTRL_OFFSET, 0);
    bus(1'b1, UPPER0_OFFSET, 32'h80000003);
    repeat (2) pulse(1'b1, 1'b0, 4);
    rd(COUNT0_OFFSET, 0, "clear at upper");
    rd(STATUS_OFFSET, 3, "ovf0 unf0");
    bus(1'b1, CTRL_OFFSET, 32'hE);
    pulse(1'b1, 1'b0, 4);
    rd(COUNT0_OFFSET, 0, "idle mode");
    bus(1'b1, LOWER1_OFFSET, 0);
    bus(1'b1, CTRL_OFFSET, 32'h1C);
    repeat (2) pulse(1'b0, 1'b1, 4);
    rd(COUNT1_OFFSET, UPPER_RESET, "wrap1");
    rd(STATUS_OFFSET, 32'hB, "unf1");
    $display("limits and filter done");
    results();
  end
endmodule // encoder_pulse_counter_decode_tb_top
bind encoder_pulse_counter_decode encoder_counter_monitor i_mon (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .encoder_in(encoder_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out));
`default_nettype wire
